// ==== hdl/adc_seq_pkg.sv ====
package adc_seq_pkg;

   // System clock: 20 MHz.
   localparam int CLK_PERIOD_NS = 50;

   // Register byte offsets on the bus.
   localparam logic [5:0] OFF_CONTROL = 6'h00;
   localparam logic [5:0] OFF_PINREF = 6'h04;
   localparam logic [5:0] OFF_TIMING = 6'h08;
   localparam logic [5:0] OFF_RES_HIGH = 6'h0C;
   localparam logic [5:0] OFF_RES_LOW = 6'h10;
   localparam logic [5:0] OFF_FLAGS = 6'h14;
   localparam logic [5:0] OFF_ENABLES = 6'h18;
   localparam logic [5:0] OFF_PRIORITY = 6'h1C;
   localparam logic [5:0] OFF_PORT = 6'h20;

   // Field positions.
   localparam int CTL_EN_BIT = 0;
   localparam int CTL_GO_BIT = 1;
   localparam int CTL_CHS_LSB = 2;
   localparam int TIM_CS_LSB = 0;
   localparam int TIM_ACQ_LSB = 3;
   localparam int TIM_JUST_BIT = 7;
   localparam int PIN_PCFG_LSB = 0;
   localparam int PIN_POSREF_BIT = 4;
   localparam int PIN_NEGREF_BIT = 5;
   localparam int FLAG_DONE_BIT = 6;

   // Reset values and implemented-bit masks.
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] TIMING_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] ENABLES_RST = 8'h00;
   localparam logic [7:0] PRIORITY_RST = 8'hFF;
   localparam logic [7:0] PINREF_RST = 8'h00;
   localparam logic [7:0] RESULT_RST = 8'h00;
   localparam logic [3:0] PCFG_ANALOG_RST = 4'h0;
   localparam logic [3:0] PCFG_DIGITAL_RST = 4'h7;
   localparam logic [7:0] CONTROL_MASK = 8'h3F;
   localparam logic [7:0] PINREF_MASK = 8'h3F;
   localparam logic [7:0] TIMING_MASK = 8'hBF;

   // Compare-module mode that routes its special event to the converter.
   localparam logic [3:0] TRIG_MODE = 4'hB;

   // Timing counts.
   localparam int INSTR_TOSC = 4;
   localparam logic [1:0] START_DLY_LAST = 2'(INSTR_TOSC - 1);
   localparam logic [3:0] CONV_TADS = 4'hB;
   localparam logic [4:0] HOLDOFF_TADS = 5'h02;

   // Acquisition lengths in conversion-clock periods, per field code.
   localparam logic [4:0] ACQ_TADS_0 = 5'h00;
   localparam logic [4:0] ACQ_TADS_1 = 5'h02;
   localparam logic [4:0] ACQ_TADS_2 = 5'h04;
   localparam logic [4:0] ACQ_TADS_3 = 5'h06;
   localparam logic [4:0] ACQ_TADS_4 = 5'h08;
   localparam logic [4:0] ACQ_TADS_5 = 5'h0C;
   localparam logic [4:0] ACQ_TADS_6 = 5'h10;
   localparam logic [4:0] ACQ_TADS_7 = 5'h14;

   // Clock-select codes, per oscillator divide ratio.
   localparam logic [2:0] CS_DIV2 = 3'h0;
   localparam logic [2:0] CS_DIV4 = 3'h4;
   localparam logic [2:0] CS_DIV8 = 3'h1;
   localparam logic [2:0] CS_DIV16 = 3'h5;
   localparam logic [2:0] CS_DIV32 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h6;
   localparam logic [1:0] CS_RC_LOW = 2'h3;

   typedef enum logic [2:0] {
      SEQ_OFF = 3'b000,
      SEQ_SAMPLE = 3'b001,
      SEQ_ACQ = 3'b010,
      SEQ_DELAY = 3'b011,
      SEQ_CONV = 3'b100,
      SEQ_HOLDOFF = 3'b101
   } seq_state_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [5:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avmm_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } avmm_rsp_t;

endpackage

// ==== hdl/tad_divider.sv ====
`timescale 1ns/10ps
module tad_divider (
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [2:0] conv_clock_sel,
   input wire logic rc_osc_in,
   output logic tad_tick
);

   typedef struct packed {
      logic [5:0] cnt;
      logic rc_s1;
      logic rc_s2;
      logic rc_s3;
   } div_state_t;

   div_state_t s_r, s_nxt;

   function automatic logic [5:0] div_last(input logic [2:0] sel);
      case (sel)
         adc_seq_pkg::CS_DIV2: div_last = 6'h01;
         adc_seq_pkg::CS_DIV4: div_last = 6'h03;
         adc_seq_pkg::CS_DIV8: div_last = 6'h07;
         adc_seq_pkg::CS_DIV16: div_last = 6'h0F;
         adc_seq_pkg::CS_DIV32: div_last = 6'h1F;
         default: div_last = 6'h3F;
      endcase
   endfunction

   logic rc_mode;

   // The RC source keeps running while the core sleeps; only its rising edges count.
   assign rc_mode = (conv_clock_sel[1:0] == adc_seq_pkg::CS_RC_LOW);
   assign tad_tick = run & (rc_mode ? (s_r.rc_s2 & ~s_r.rc_s3) : (s_r.cnt == div_last(conv_clock_sel)));

   always_comb begin
      s_nxt = s_r;
      s_nxt.rc_s1 = rc_osc_in;
      s_nxt.rc_s2 = s_r.rc_s1;
      s_nxt.rc_s3 = s_r.rc_s2;
      if (!run || tad_tick || rc_mode) begin
         s_nxt.cnt = 6'h00;
      end else begin
         s_nxt.cnt = 6'(s_r.cnt + 6'h01);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// ==== hdl/sar_core.sv ====
`timescale 1ns/10ps
module sar_core (
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire logic abort,
   input wire logic tad_tick,
   input wire logic cmp_above,
   output logic [9:0] dac_code,
   output logic done
);

   typedef struct packed {
      logic busy;
      logic [3:0] tads;
      logic [9:0] code;
      logic [9:0] mask;
      logic done;
   } sar_state_t;

   sar_state_t s_r, s_nxt;

   assign dac_code = s_r.code;
   assign done = s_r.done;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (abort) begin
         s_nxt.busy = 1'b0;
      end else if (start) begin
         s_nxt.busy = 1'b1;
         s_nxt.tads = 4'h0;
         s_nxt.code = 10'h000;
         s_nxt.mask = 10'h000;
      end else if (s_r.busy && tad_tick) begin
         s_nxt.tads = 4'(s_r.tads + 4'h1);
         if (s_r.tads == 4'h0) begin
            s_nxt.code = 10'h200;
            s_nxt.mask = 10'h200;
         end else begin
            // A low comparator means the trial level overshot the input.
            s_nxt.code = (cmp_above ? s_r.code : (s_r.code & ~s_r.mask)) | (s_r.mask >> 1);
            s_nxt.mask = s_r.mask >> 1;
         end
         if (4'(s_r.tads + 4'h1) == adc_seq_pkg::CONV_TADS) begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// ==== hdl/adc_sequencer.sv ====
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/10ps
// Notes on behaviour
// - Zero acquisition: start waits one instruction cycle.
// - Code 010 samples four periods, then converts.
// - Clearing go aborts a running conversion at once.
// - Abort leaves result registers untouched.
// - Two-period hold-off after completion or abort; disabling goes straight to off without it.
// - After hold-off, sampling resumes automatically.
// - Mode 1011 trigger sets go, clears timer.
// - Disabled converter ignores trigger; timer still cleared.
// - Channel and direction bits never gate sequencing.
// - Analog pins read as zero from port.
// - Output-direction pins still get converted.
// - Control registers reset to zero except priority (all ones), pin configuration then set from strap, converter idle.
// - One conversion takes eleven conversion-clock periods.
// - Completion clears go, sets flag, resumes sampling.
// - Zero acquisition: go skips acquisition, converts after one instruction cycle.
// - Clock field selects divide ratio or RC.
module adc_sequencer #(
   parameter int N_CHANNELS = 13
) (
   input wire logic clk,
   input wire logic resetn,
   input adc_seq_pkg::avmm_req_t avs_req,
   output adc_seq_pkg::avmm_rsp_t avs_rsp,
   input wire logic [3:0] compare2_mode_field,
   input wire logic special_event_trig,
   output logic timer_clear,
   input wire logic rc_osc_in,
   input wire logic cmp_above,
   input wire logic portb_analog_reset_cfg,
   input wire logic [N_CHANNELS-1:0] port_pins_in,
   output logic [3:0] channel_sel,
   output logic sample_en,
   output logic [9:0] dac_code,
   output logic conv_enable,
   output logic conv_done_flag,
   output logic conv_done_irq_en,
   output logic conv_irq_priority,
   output logic pos_ref_sel,
   output logic neg_ref_sel
);

   typedef struct packed {
      adc_seq_pkg::seq_state_t st;
      logic [4:0] cnt;
      logic [1:0] dly;
      logic go;
      logic en;
      logic [3:0] chs;
      logic [7:0] pinref;
      logic [7:0] timing;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [7:0] flags;
      logic [7:0] enables;
      logic [7:0] priority_bits;
      logic ack;
      logic [31:0] rdata;
      logic tclr;
      logic [1:0] init;
      logic strap_s1;
      logic strap_s2;
      logic cmp_s1;
      logic cmp_s2;
      logic [N_CHANNELS-1:0] pins_s1;
      logic [N_CHANNELS-1:0] pins_s2;
   } seq_reg_t;

   seq_reg_t s_r, s_nxt;

   logic tad_tick;
   logic sar_start;
   logic sar_abort;
   logic sar_done;
   logic [9:0] sar_code;
   logic div_run;

   function automatic logic [4:0] acq_tads(input logic [2:0] code);
      case (code)
         3'h0: acq_tads = adc_seq_pkg::ACQ_TADS_0;
         3'h1: acq_tads = adc_seq_pkg::ACQ_TADS_1;
         3'h2: acq_tads = adc_seq_pkg::ACQ_TADS_2;
         3'h3: acq_tads = adc_seq_pkg::ACQ_TADS_3;
         3'h4: acq_tads = adc_seq_pkg::ACQ_TADS_4;
         3'h5: acq_tads = adc_seq_pkg::ACQ_TADS_5;
         3'h6: acq_tads = adc_seq_pkg::ACQ_TADS_6;
         default: acq_tads = adc_seq_pkg::ACQ_TADS_7;
      endcase
   endfunction

   // Channels below the boundary set by the pin configuration are analog.
   function automatic logic [N_CHANNELS-1:0] analog_mask(input logic [3:0] pcfg);
      logic [N_CHANNELS-1:0] m;
      m = '0;
      for (int i = 0; i < N_CHANNELS; i++) begin
         m[i] = (i < (15 - int'(pcfg)));
      end
      return m;
   endfunction

   tad_divider u_div (
      .clk(clk),
      .resetn(resetn),
      .run(div_run),
      .conv_clock_sel(s_r.timing[adc_seq_pkg::TIM_CS_LSB +: 3]),
      .rc_osc_in(rc_osc_in),
      .tad_tick(tad_tick)
   );

   sar_core u_sar (
      .clk(clk),
      .resetn(resetn),
      .start(sar_start),
      .abort(sar_abort),
      .tad_tick(tad_tick),
      .cmp_above(s_r.cmp_s2),
      .dac_code(sar_code),
      .done(sar_done)
   );

   assign div_run = (s_r.st != adc_seq_pkg::SEQ_OFF);
   assign avs_rsp.readdata = s_r.rdata;
   assign avs_rsp.waitrequest = (avs_req.read | avs_req.write) & ~s_r.ack;
   assign timer_clear = s_r.tclr;
   // The channel is handed to the analog mux whatever the pin direction is.
   assign channel_sel = s_r.chs;
   assign sample_en = (s_r.st == adc_seq_pkg::SEQ_SAMPLE) || (s_r.st == adc_seq_pkg::SEQ_ACQ);
   assign dac_code = sar_code;
   assign conv_enable = s_r.en;
   assign conv_done_flag = s_r.flags[adc_seq_pkg::FLAG_DONE_BIT];
   assign conv_done_irq_en = s_r.enables[adc_seq_pkg::FLAG_DONE_BIT];
   assign conv_irq_priority = s_r.priority_bits[adc_seq_pkg::FLAG_DONE_BIT];
   assign pos_ref_sel = s_r.pinref[adc_seq_pkg::PIN_POSREF_BIT];
   assign neg_ref_sel = s_r.pinref[adc_seq_pkg::PIN_NEGREF_BIT];

   always_comb begin
      logic wr;
      logic [7:0] wd;
      logic [7:0] rbyte;
      logic [31:0] rword;
      logic set_go;
      logic clr_go;
      logic trig_hit;
      logic [4:0] acq_len;
      logic [9:0] res;
      wr = avs_req.write & s_r.ack & avs_req.byteenable[0];
      wd = avs_req.writedata[7:0];
      rbyte = 8'h00;
      rword = 32'h0000_0000;
      set_go = 1'b0;
      clr_go = 1'b0;
      trig_hit = (compare2_mode_field == adc_seq_pkg::TRIG_MODE) & special_event_trig;
      acq_len = acq_tads(s_r.timing[adc_seq_pkg::TIM_ACQ_LSB +: 3]);
      res = sar_code;
      sar_start = 1'b0;
      sar_abort = 1'b0;
      s_nxt = s_r;

      s_nxt.strap_s1 = portb_analog_reset_cfg;
      s_nxt.strap_s2 = s_r.strap_s1;
      s_nxt.cmp_s1 = cmp_above;
      s_nxt.cmp_s2 = s_r.cmp_s1;
      s_nxt.pins_s1 = port_pins_in;
      s_nxt.pins_s2 = s_r.pins_s1;
      // The strap is caught once its synchroniser has settled after reset.
      if (s_r.init != 2'h3) begin
         s_nxt.init = 2'(s_r.init + 2'h1);
      end
      if (s_r.init == 2'h2) begin
         s_nxt.pinref[adc_seq_pkg::PIN_PCFG_LSB +: 4] = s_r.strap_s2 ? adc_seq_pkg::PCFG_ANALOG_RST
                                                                     : adc_seq_pkg::PCFG_DIGITAL_RST;
      end

      // One wait state: a write is taken on the edge where ack is high; a read is sampled one edge earlier.
      s_nxt.ack = (avs_req.read | avs_req.write) & ~s_r.ack;
      if (avs_req.read && !s_r.ack) begin
         case (avs_req.address)
            adc_seq_pkg::OFF_CONTROL: rbyte = {2'b00, s_r.chs, s_r.go, s_r.en};
            adc_seq_pkg::OFF_PINREF: rbyte = s_r.pinref;
            adc_seq_pkg::OFF_TIMING: rbyte = s_r.timing;
            adc_seq_pkg::OFF_RES_HIGH: rbyte = s_r.res_hi;
            adc_seq_pkg::OFF_RES_LOW: rbyte = s_r.res_lo;
            adc_seq_pkg::OFF_FLAGS: rbyte = s_r.flags;
            adc_seq_pkg::OFF_ENABLES: rbyte = s_r.enables;
            adc_seq_pkg::OFF_PRIORITY: rbyte = s_r.priority_bits;
            default: rbyte = 8'h00;
         endcase
         rword = {24'h00_0000, rbyte};
         if (avs_req.address == adc_seq_pkg::OFF_PORT) begin
            rword = 32'(s_r.pins_s2 & ~analog_mask(s_r.pinref[adc_seq_pkg::PIN_PCFG_LSB +: 4]));
         end
         s_nxt.rdata = rword;
      end

      if (wr) begin
         case (avs_req.address)
            adc_seq_pkg::OFF_CONTROL: begin
               s_nxt.en = wd[adc_seq_pkg::CTL_EN_BIT];
               s_nxt.chs = wd[adc_seq_pkg::CTL_CHS_LSB +: 4];
               // Go only counts when enable was already on before this write.
               set_go = wd[adc_seq_pkg::CTL_GO_BIT] & s_r.en;
               clr_go = ~wd[adc_seq_pkg::CTL_GO_BIT];
            end
            adc_seq_pkg::OFF_PINREF: s_nxt.pinref = wd & adc_seq_pkg::PINREF_MASK;
            adc_seq_pkg::OFF_TIMING: s_nxt.timing = wd & adc_seq_pkg::TIMING_MASK;
            adc_seq_pkg::OFF_RES_HIGH: s_nxt.res_hi = wd;
            adc_seq_pkg::OFF_RES_LOW: s_nxt.res_lo = wd;
            adc_seq_pkg::OFF_FLAGS: s_nxt.flags = wd;
            adc_seq_pkg::OFF_ENABLES: s_nxt.enables = wd;
            adc_seq_pkg::OFF_PRIORITY: s_nxt.priority_bits = wd;
            default: ;
         endcase
      end

      s_nxt.tclr = trig_hit;
      if (trig_hit && s_r.en) begin
         set_go = 1'b1;
      end

      case (s_r.st)
         adc_seq_pkg::SEQ_OFF: begin
            s_nxt.go = 1'b0;
            if (s_r.en) begin
               s_nxt.st = adc_seq_pkg::SEQ_SAMPLE;
            end
         end
         adc_seq_pkg::SEQ_SAMPLE: begin
            if (set_go) begin
               s_nxt.go = 1'b1;
               s_nxt.cnt = 5'h00;
               s_nxt.dly = 2'h0;
               if (acq_len == adc_seq_pkg::ACQ_TADS_0) begin
                  s_nxt.st = adc_seq_pkg::SEQ_DELAY;
               end else begin
                  s_nxt.st = adc_seq_pkg::SEQ_ACQ;
               end
            end
         end
         adc_seq_pkg::SEQ_ACQ: begin
            if (clr_go) begin
               s_nxt.go = 1'b0;
               s_nxt.cnt = 5'h00;
               s_nxt.st = adc_seq_pkg::SEQ_HOLDOFF;
            end else if (tad_tick) begin
               s_nxt.cnt = 5'(s_r.cnt + 5'h01);
               if (5'(s_r.cnt + 5'h01) >= acq_len) begin
                  sar_start = 1'b1;
                  s_nxt.st = adc_seq_pkg::SEQ_CONV;
               end
            end
         end
         adc_seq_pkg::SEQ_DELAY: begin
            if (clr_go) begin
               s_nxt.go = 1'b0;
               s_nxt.cnt = 5'h00;
               s_nxt.st = adc_seq_pkg::SEQ_HOLDOFF;
            end else begin
               s_nxt.dly = 2'(s_r.dly + 2'h1);
               if (s_r.dly == adc_seq_pkg::START_DLY_LAST) begin
                  sar_start = 1'b1;
                  s_nxt.st = adc_seq_pkg::SEQ_CONV;
               end
            end
         end
         adc_seq_pkg::SEQ_CONV: begin
            // Further go writes or triggers find go already set and are ignored.
            if (clr_go) begin
               sar_abort = 1'b1;
               s_nxt.go = 1'b0;
               s_nxt.cnt = 5'h00;
               s_nxt.st = adc_seq_pkg::SEQ_HOLDOFF;
            end else if (sar_done) begin
               if (s_r.timing[adc_seq_pkg::TIM_JUST_BIT]) begin
                  s_nxt.res_hi = {6'h00, res[9:8]};
                  s_nxt.res_lo = res[7:0];
               end else begin
                  s_nxt.res_hi = res[9:2];
                  s_nxt.res_lo = {res[1:0], 6'h00};
               end
               s_nxt.flags[adc_seq_pkg::FLAG_DONE_BIT] = 1'b1;
               s_nxt.go = 1'b0;
               s_nxt.cnt = 5'h00;
               s_nxt.st = adc_seq_pkg::SEQ_HOLDOFF;
            end
         end
         adc_seq_pkg::SEQ_HOLDOFF: begin
            if (set_go) begin
               s_nxt.go = 1'b1;
            end else if (clr_go) begin
               s_nxt.go = 1'b0;
            end
            if (tad_tick) begin
               s_nxt.cnt = 5'(s_r.cnt + 5'h01);
               if (5'(s_r.cnt + 5'h01) == adc_seq_pkg::HOLDOFF_TADS) begin
                  s_nxt.st = adc_seq_pkg::SEQ_SAMPLE;
               end
            end
         end
         default: s_nxt.st = adc_seq_pkg::SEQ_OFF;
      endcase

      // A pending go leaves hold-off straight into the next sequence.
      if (s_r.st == adc_seq_pkg::SEQ_HOLDOFF && s_nxt.st == adc_seq_pkg::SEQ_SAMPLE && s_nxt.go) begin
         s_nxt.cnt = 5'h00;
         s_nxt.dly = 2'h0;
         s_nxt.st = (acq_len == adc_seq_pkg::ACQ_TADS_0) ? adc_seq_pkg::SEQ_DELAY : adc_seq_pkg::SEQ_ACQ;
      end

      if (!s_nxt.en) begin
         sar_abort = 1'b1;
         sar_start = 1'b0;
         s_nxt.go = 1'b0;
         s_nxt.st = adc_seq_pkg::SEQ_OFF;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.st <= adc_seq_pkg::SEQ_OFF;
         s_r.en <= adc_seq_pkg::CONTROL_RST[adc_seq_pkg::CTL_EN_BIT];
         s_r.go <= adc_seq_pkg::CONTROL_RST[adc_seq_pkg::CTL_GO_BIT];
         s_r.chs <= adc_seq_pkg::CONTROL_RST[adc_seq_pkg::CTL_CHS_LSB +: 4];
         s_r.pinref <= adc_seq_pkg::PINREF_RST;
         s_r.timing <= adc_seq_pkg::TIMING_RST;
         s_r.res_hi <= adc_seq_pkg::RESULT_RST;
         s_r.res_lo <= adc_seq_pkg::RESULT_RST;
         s_r.flags <= adc_seq_pkg::FLAGS_RST;
         s_r.enables <= adc_seq_pkg::ENABLES_RST;
         s_r.priority_bits <= adc_seq_pkg::PRIORITY_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule

// ==== sim/adc_sequencer_assertions.sv ====
`timescale 1ns/10ps
module adc_sequencer_checker (
   input wire logic clk,
   input wire logic resetn,
   input adc_seq_pkg::avmm_req_t avs_req,
   input adc_seq_pkg::avmm_rsp_t avs_rsp,
   input wire logic [3:0] compare2_mode_field,
   input wire logic special_event_trig,
   input wire logic timer_clear,
   input wire logic sample_en,
   input wire logic conv_enable,
   input wire logic conv_done_flag
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_one_wait;
      avs_rsp.waitrequest ##1 !avs_rsp.waitrequest;
   endsequence

   sequence s_armed_trig;
      special_event_trig && compare2_mode_field == adc_seq_pkg::TRIG_MODE;
   endsequence

   a_trig_clears_timer: assert property (s_armed_trig |=> timer_clear)
      else $error("timer clear missing after armed trigger");
   a_clear_has_cause: assert property (timer_clear |-> $past(special_event_trig) &&
      $past(compare2_mode_field) == adc_seq_pkg::TRIG_MODE)
      else $error("timer clear without armed trigger");
   a_bus_one_wait: assert property ($rose(avs_req.read || avs_req.write) |-> s_one_wait)
      else $error("bus answer not after exactly one wait cycle");
   a_bus_idle_free: assert property (!avs_req.read && !avs_req.write |-> !avs_rsp.waitrequest)
      else $error("waitrequest high without a request");
   a_off_is_idle: assert property (!conv_enable && !$past(conv_enable) |-> !sample_en)
      else $error("sampling while converter disabled");
   a_done_holdoff: assert property ($rose(conv_done_flag) |-> !sample_en ##1 !sample_en)
      else $error("sampling resumed before hold-off");
   a_done_resumes: assert property ($rose(conv_done_flag) |-> ##[1:400] sample_en)
      else $error("sampling did not resume after hold-off");
   a_done_after_conv: assert property ($rose(conv_done_flag) |-> !$past(sample_en))
      else $error("done flag set while sampling");
   a_conv_min_len: assert property ($fell(sample_en) |-> (!$rose(conv_done_flag)) [*8])
      else $error("conversion finished too early");
endmodule

bind adc_sequencer adc_sequencer_checker u_chk (.clk(clk), .resetn(resetn), .avs_req(avs_req),
   .avs_rsp(avs_rsp), .compare2_mode_field(compare2_mode_field), .special_event_trig(special_event_trig),
   .timer_clear(timer_clear), .sample_en(sample_en), .conv_enable(conv_enable),
   .conv_done_flag(conv_done_flag));

// ==== sim/adc_far_side.sv ====
`timescale 1ns/10ps
module adc_far_side (
   input wire logic clk,
   input wire logic [9:0] dac_code,
   input wire logic [9:0] level,
   input wire logic fire,
   output logic cmp_above = 1'b0,
   output logic special_event_trig = 1'b0,
   output logic rc_osc_in = 1'b0
);
   logic [1:0] rc_cnt = 2'h0;

   // The input sits half a step above level, so a trial at or below level reads as above.
   always_ff @(posedge clk) begin
      cmp_above <= dac_code <= level;
      special_event_trig <= fire;
      rc_cnt <= rc_cnt + 2'h1;
      rc_osc_in <= rc_cnt[1];
   end
endmodule

// ==== sim/adc_sequencer_tb_top.sv ====
`timescale 1ns/10ps
module adc_sequencer_tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   adc_seq_pkg::avmm_req_t req = '{byteenable: 4'hF, default: '0};
   adc_seq_pkg::avmm_rsp_t rsp;
   logic [3:0] mode = 4'h0;
   logic fire = 1'b0;
   logic [9:0] level = 10'h000;
   logic [12:0] pins = 13'h0000;
   logic trig, rc, cmp, sample_en;
   logic [9:0] dac;
   logic [31:0] rnd = 32'h00013566;
   logic [7:0] q;
   int err_count = 0;
   int num_checks = 0;
   int c;

   always #(adc_seq_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

   adc_sequencer dut (.clk(clk), .resetn(resetn), .avs_req(req), .avs_rsp(rsp),
      .compare2_mode_field(mode), .special_event_trig(trig), .timer_clear(), .rc_osc_in(rc),
      .cmp_above(cmp), .portb_analog_reset_cfg(1'b1), .port_pins_in(pins), .channel_sel(),
      .sample_en(sample_en), .dac_code(dac), .conv_enable(), .conv_done_flag(), .conv_done_irq_en(),
      .conv_irq_priority(), .pos_ref_sel(), .neg_ref_sel());

   adc_far_side far (.clk(clk), .dac_code(dac), .level(level), .fire(fire), .cmp_above(cmp),
      .special_event_trig(trig), .rc_osc_in(rc));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Holds the request until waitrequest is sampled low, then releases it.
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      req.read <= !wr;
      req.write <= wr;
      req.address <= a;
      req.writedata <= {24'h000000, d};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.waitrequest !== 1'b0 && n < 50);
      q = rsp.readdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
      if (n >= 50) begin
         err_count++;
         wrap_up();
      end
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         bus(1'b0, adc_seq_pkg::OFF_CONTROL, 8'h00);
         n++;
      end while (q[1] !== 1'b0 && n < 1000);
      if (n >= 1000) begin
         err_count++;
         wrap_up();
      end
      bus(1'b0, adc_seq_pkg::OFF_FLAGS, 8'h00);
      check8("done_flag", 8'h40, q & 8'h40);
      bus(1'b1, adc_seq_pkg::OFF_FLAGS, 8'h00);
   endtask

   // A go written during hold-off skips sampling, so scenarios that watch sampling wait for it first.
   task automatic wait_sampling();
      c = 0;
      while (sample_en !== 1'b1 && c < 300) begin
         @(posedge clk);
         c++;
      end
      if (c >= 300) begin
         err_count++;
         wrap_up();
      end
   endtask

   task automatic convert(input logic [7:0] tim, input logic by_trig);
      logic [15:0] e;
      rnd = lfsr(rnd);
      // The /2 clock leaves a trial level too little time to cross the comparator synchroniser,
      // so only full scale converts exactly there.
      level <= (tim[2:0] == 3'h0) ? 10'h3FF : rnd[9:0];
      pins <= rnd[22:10];
      // The clock source chosen here stays until the conversion has ended.
      bus(1'b1, adc_seq_pkg::OFF_TIMING, tim);
      if (by_trig) begin
         @(posedge clk);
         fire <= 1'b1;
         @(posedge clk);
         fire <= 1'b0;
      end else
         bus(1'b1, adc_seq_pkg::OFF_CONTROL, {2'b00, rnd[26:23], 2'b11});
      bus(1'b1, adc_seq_pkg::OFF_CONTROL, {2'b00, rnd[26:23], 2'b11});
      wait_idle();
      e = tim[7] ? {6'h00, level} : {level, 6'h00};
      bus(1'b0, adc_seq_pkg::OFF_RES_HIGH, 8'h00);
      check8("result_high", e[15:8], q);
      bus(1'b0, adc_seq_pkg::OFF_RES_LOW, 8'h00);
      check8("result_low", e[7:0], q);
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      wrap_up();
   end

   initial begin
      automatic logic [2:0] cs [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
      pins <= 13'h1A5C;
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      repeat (5) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         bus(1'b0, 6'(i * 4), 8'h00);
         check8("reset_value", (i == 7) ? 8'hFF : 8'h00, q);
      end
      bus(1'b1, adc_seq_pkg::OFF_PINREF, 8'h0D);
      bus(1'b0, adc_seq_pkg::OFF_PORT, 8'h00);
      check8("port_read", pins[7:0] & 8'hFC, q);
      bus(1'b1, adc_seq_pkg::OFF_CONTROL, 8'h01);
      mode <= adc_seq_pkg::TRIG_MODE;
      // Codes x11 run from the RC source, as software must pick for a conversion meant for sleep.
      for (int i = 0; i < 8; i++)
         convert({i[0], 1'b0, 3'(i), cs[i]}, i == 5);
      bus(1'b1, adc_seq_pkg::OFF_TIMING, 8'h11);
      wait_sampling();
      bus(1'b1, adc_seq_pkg::OFF_CONTROL, 8'h03);
      c = 0;
      while (sample_en === 1'b1 && c < 200) begin
         @(posedge clk);
         c++;
      end
      check8("acq_length_ok", 8'h01, {7'h00, c >= 24 && c <= 34});
      wait_idle();
      bus(1'b1, adc_seq_pkg::OFF_TIMING, 8'h01);
      wait_sampling();
      bus(1'b1, adc_seq_pkg::OFF_CONTROL, 8'h03);
      @(negedge clk);
      check8("sample_after_go", 8'h00, {7'h00, sample_en});
      wait_idle();
      bus(1'b1, adc_seq_pkg::OFF_TIMING, 8'h06);
      bus(1'b1, adc_seq_pkg::OFF_RES_HIGH, 8'hA5);
      bus(1'b1, adc_seq_pkg::OFF_RES_LOW, 8'h5A);
      for (int k = 0; k < 2; k++) begin
         wait_sampling();
         bus(1'b1, adc_seq_pkg::OFF_CONTROL, 8'h03);
         repeat (200) @(posedge clk);
         bus(1'b1, adc_seq_pkg::OFF_CONTROL, k ? 8'h00 : 8'h01);
         bus(1'b0, adc_seq_pkg::OFF_CONTROL, 8'h00);
         check8("abort_ctrl", k ? 8'h00 : 8'h01, q);
         bus(1'b0, adc_seq_pkg::OFF_RES_HIGH, 8'h00);
         check8("abort_high", 8'hA5, q);
         bus(1'b0, adc_seq_pkg::OFF_RES_LOW, 8'h00);
         check8("abort_low", 8'h5A, q);
         repeat (200) @(posedge clk);
      end
      @(posedge clk);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      bus(1'b0, adc_seq_pkg::OFF_CONTROL, 8'h00);
      check8("trig_disabled", 8'h00, q);
      bus(1'b1, adc_seq_pkg::OFF_CONTROL, 8'h03);
      bus(1'b0, adc_seq_pkg::OFF_CONTROL, 8'h00);
      check8("go_with_enable", 8'h01, q);
      wrap_up();
   end
endmodule
